// [bench/trace_probe_model.sv]
// software or debug probe model issuing full-word window accesses
module trace_probe_model
  import trace_word_pkg::*;
(
  // clock
  input  wire logic              clk_in,
  // register port
  input  wire logic              ack_in,
  input  wire logic [DATA_W-1:0] rdata_in,
  output logic                   req_out,
  output logic                   write_out,
  output logic      [ADDR_W-1:0] addr_out,
  output logic      [DATA_W-1:0] wdata_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    req_out = 1'b0;
    write_out = 1'b0;
    addr_out = '0;
    wdata_out = '0;
  end

  // one 32-bit access held until acknowledged, then lines scrambled
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                        output logic [DATA_W-1:0] r);
    @(posedge clk_in);
    req_out   <= 1'b1;
    write_out <= wr;
    addr_out  <= a;
    wdata_out <= d;
    do @(posedge clk_in); while (ack_in !== 1'b1);
    r = rdata_in;
    req_out   <= 1'b0;
    write_out <= ~wr;
    addr_out  <= ~a;
    wdata_out <= ~d;
  endtask

  // high half first, low half moves the pointer
  task automatic word_xfer(input logic wr, input logic [WORD_W-1:0] w, output logic [WORD_W-1:0] r);
    access(wr, TRACE_WORD_HI_OFF, w[63:32], r[63:32]);
    access(wr, TRACE_WORD_LO_OFF, w[31:0], r[31:0]);
  endtask
endmodule

// [bench/trace_word_access_tb.sv]
// self-checking bench for the trace word access port
module trace_word_access_tb import trace_word_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clk_in = 1'b0;
  logic              reset_in = 1'b1;
  logic              trace_valid_in = 1'b0;
  logic              ce_in = 1'b1;
  logic              ce_gaps = 1'b0;
  logic [WORD_W-1:0] trace_word_in = '0;
  logic              cpu_req, cpu_write, cpu_ack, dbg_req, dbg_write, dbg_ack;
  logic [ADDR_W-1:0] cpu_addr, dbg_addr;
  logic [DATA_W-1:0] cpu_wdata, cpu_rdata, dbg_wdata, dbg_rdata, rp, wp;
  logic [WORD_W-1:0] mem [DEPTH];
  logic [WORD_W-1:0] got, w;
  int                miscompares = 0, total_checks = 0, cycles = 0, seed_v;

  always #2 clk_in = ~clk_in;

  trace_word_access i_dut (.clk_in(clk_in), .reset_in(reset_in), .ce_in(ce_in),
    .cpu_req_in(cpu_req), .cpu_write_in(cpu_write), .cpu_addr_in(cpu_addr), .cpu_wdata_in(cpu_wdata),
    .cpu_ack_out(cpu_ack), .cpu_rdata_out(cpu_rdata), .dbg_req_in(dbg_req), .dbg_write_in(dbg_write),
    .dbg_addr_in(dbg_addr), .dbg_wdata_in(dbg_wdata), .dbg_ack_out(dbg_ack), .dbg_rdata_out(dbg_rdata),
    .trace_valid_in(trace_valid_in), .trace_word_in(trace_word_in),
    .trace_read_pointer_out(rp), .trace_write_pointer_out(wp));
  trace_probe_model i_cpu (.clk_in(clk_in), .ack_in(cpu_ack), .rdata_in(cpu_rdata), .req_out(cpu_req),
    .write_out(cpu_write), .addr_out(cpu_addr), .wdata_out(cpu_wdata));
  trace_probe_model i_dbg (.clk_in(clk_in), .ack_in(dbg_ack), .rdata_in(dbg_rdata), .req_out(dbg_req),
    .write_out(dbg_write), .addr_out(dbg_addr), .wdata_out(dbg_wdata));

  function automatic logic [DATA_W-1:0] ptr_of(int idx);
    return {PTR_HIGH_ZERO, idx[5:0], PTR_LOW_ZERO};
  endfunction

  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks=%0d miscompares=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // one-cycle enable gaps at random, at least two enabled cycles apart
  always @(posedge clk_in) begin
    ce_in <= !(ce_gaps && (cycles % 3 == 0) && ($urandom_range(1) == 1));
  end

  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      miscompares++;
      wrap_up();
    end
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    seed_v = $urandom(5);
    repeat (12) @(posedge clk_in);
    reset_in <= 1'b0;
    i_cpu.word_xfer(1'b0, '0, got);
    check(got[63:32], WIN_RESET);
    check(got[31:0], WIN_RESET);
    check(rp, ptr_of(1));
    check(wp, ptr_of(0));
    // lone high read and unmapped accesses move nothing
    i_cpu.access(1'b0, TRACE_WORD_HI_OFF, '0, got[31:0]);
    check(got[31:0], WIN_RESET);
    i_cpu.access(1'b1, 12'h0204, 32'hdead_beef, got[31:0]);
    i_cpu.access(1'b0, 12'h0204, '0, got[31:0]);
    check(got[31:0], 32'h0000_0000);
    check(rp, ptr_of(1));
    check(wp, ptr_of(0));
    ce_gaps = 1'b1;
    for (int i = 0; i < DEPTH; i++) begin
      w = (i == DEPTH - 1) ? '1 : {$urandom, $urandom};
      mem[i] = w;
      if ($urandom_range(1) == 1) begin
        i_cpu.word_xfer(1'b1, w, got);
      end else begin
        i_dbg.word_xfer(1'b1, w, got);
      end
      check(wp, ptr_of(i + 1));
    end
    ce_gaps = 1'b0;
    // producer word lands at the write pointer
    w = {$urandom, $urandom};
    @(posedge clk_in);
    trace_valid_in <= 1'b1;
    trace_word_in  <= w;
    @(posedge clk_in);
    trace_valid_in <= 1'b0;
    @(posedge clk_in);
    mem[0] = w;
    check(wp, ptr_of(1));
    ce_gaps = 1'b1;
    for (int i = 1; i <= DEPTH; i++) begin
      if ($urandom_range(1) == 1) begin
        i_dbg.word_xfer(1'b0, '0, got);
      end else begin
        i_cpu.word_xfer(1'b0, '0, got);
      end
      check(got[63:32], mem[i % DEPTH][63:32]);
      check(got[31:0], mem[i % DEPTH][31:0]);
      check(rp, ptr_of(i + 1));
    end
    ce_gaps = 1'b0;
    // producer, cpu and probe collide; producer first, then cpu, then probe
    w = {$urandom, $urandom};
    mem[1] = w;
    fork
      i_cpu.access(1'b0, TRACE_WORD_HI_OFF, '0, got[63:32]);
      i_dbg.access(1'b0, TRACE_WORD_HI_OFF, '0, got[31:0]);
      begin
        @(posedge clk_in);
        trace_valid_in <= 1'b1;
        trace_word_in  <= w;
        @(posedge clk_in);
        trace_valid_in <= 1'b0;
      end
    join
    check(got[63:32], w[63:32]);
    check(got[31:0], w[63:32]);
    check(wp, ptr_of(2));
    check(rp, ptr_of(1));
    wrap_up();
  end
endmodule

// [hdl/trace_word_access.sv]
// trace memory word access port with cpu and debug-probe register ports
// ---------------------------------------------------------------
// Summary of operation
// - a low-window read returns bits 31:0 of the word at the read pointer, a write replaces bits 31:0 at the write pointer.
// - a high-window read returns bits 63:32 of the word at the read pointer, a write replaces bits 63:32 at the write pointer.
// - every low-window read moves the read pointer to the next word, wrapping from the last location to zero.
// - every low-window write moves the write pointer to the next word, wrapping from the last location to zero.
// - both windows are also reachable from the debug probe port that carries the trace-data instruction.
// - both windows are 32 bits, readable and writable, and read as zero after reset.
// - the pointers are byte addresses of 64-bit words, so their three low bits always read zero.
// - the write pointer always names the location where the next produced trace word is stored.
module trace_word_access
  import trace_word_pkg::*;
(
  // clock, reset, enable
  input  wire logic              clk_in,
  input  wire logic              reset_in,
  input  wire logic              ce_in,
  // cpu register port
  input  wire logic              cpu_req_in,
  input  wire logic              cpu_write_in,
  input  wire logic [ADDR_W-1:0] cpu_addr_in,
  input  wire logic [DATA_W-1:0] cpu_wdata_in,
  output logic                   cpu_ack_out,
  output logic      [DATA_W-1:0] cpu_rdata_out,
  // debug probe trace-data instruction port
  input  wire logic              dbg_req_in,
  input  wire logic              dbg_write_in,
  input  wire logic [ADDR_W-1:0] dbg_addr_in,
  input  wire logic [DATA_W-1:0] dbg_wdata_in,
  output logic                   dbg_ack_out,
  output logic      [DATA_W-1:0] dbg_rdata_out,
  // trace word producer
  input  wire logic              trace_valid_in,
  input  wire logic [WORD_W-1:0] trace_word_in,
  // pointer view
  output logic      [DATA_W-1:0] trace_read_pointer_out,
  output logic      [DATA_W-1:0] trace_write_pointer_out
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [WORD_W-1:0] mem_q [DEPTH];
  logic [IDX_W-1:0]  rd_idx_q;
  logic [IDX_W-1:0]  wr_idx_q;
  logic              cpu_ack_q;
  logic              dbg_ack_q;
  logic [DATA_W-1:0] cpu_rdata_q;
  logic [DATA_W-1:0] dbg_rdata_q;

  // ---------------------------------------------------------------
  // arbitration: producer, then cpu, then debug probe
  // ---------------------------------------------------------------
  logic              cpu_pend;
  logic              take_cpu;
  logic              take_dbg;
  logic              take_acc;
  logic              acc_write;
  logic [ADDR_W-1:0] acc_addr;
  logic [DATA_W-1:0] acc_wdata;
  logic              hit_lo;
  logic              hit_hi;
  logic              rd_lo;
  logic              wr_lo;
  logic [IDX_W-1:0]  rd_idx_d;
  logic [IDX_W-1:0]  wr_idx_d;
  logic [WORD_W-1:0] rd_word;
  logic [DATA_W-1:0] rd_half;

  assign cpu_pend  = cpu_req_in && !cpu_ack_q;
  assign take_cpu  = ce_in && cpu_pend && !trace_valid_in;
  assign take_dbg  = ce_in && dbg_req_in && !dbg_ack_q && !trace_valid_in && !cpu_pend;
  assign take_acc  = take_cpu || take_dbg;
  assign acc_write = take_cpu ? cpu_write_in : dbg_write_in;
  assign acc_addr  = take_cpu ? cpu_addr_in  : dbg_addr_in;
  assign acc_wdata = take_cpu ? cpu_wdata_in : dbg_wdata_in;
  assign hit_lo    = (acc_addr == TRACE_WORD_LO_OFF);
  assign hit_hi    = (acc_addr == TRACE_WORD_HI_OFF);
  assign rd_lo     = take_acc && !acc_write && hit_lo;
  assign wr_lo     = take_acc && acc_write && hit_lo;
  assign rd_word   = mem_q[rd_idx_q];

  always_comb begin
    if (hit_lo) begin
      rd_half = rd_word[31:0];
    end else if (hit_hi) begin
      rd_half = rd_word[63:32];
    end else begin
      rd_half = WIN_RESET;
    end
  end

  // ---------------------------------------------------------------
  // pointers
  // ---------------------------------------------------------------
  assign rd_idx_d = (rd_idx_q == IDX_LAST) ? PTR_RESET : rd_idx_q + IDX_ONE;
  assign wr_idx_d = (wr_idx_q == IDX_LAST) ? PTR_RESET : wr_idx_q + IDX_ONE;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rd_idx_q <= PTR_RESET;
    end else if (ce_in && rd_lo) begin
      rd_idx_q <= rd_idx_d;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      wr_idx_q <= PTR_RESET;
    end else if (ce_in && (trace_valid_in || wr_lo)) begin
      wr_idx_q <= wr_idx_d;
    end
  end

  // ---------------------------------------------------------------
  // trace memory
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= WORD_RESET;
      end
    end else if (ce_in) begin
      if (trace_valid_in) begin
        mem_q[wr_idx_q] <= trace_word_in;
      end else if (take_acc && acc_write && hit_lo) begin
        mem_q[wr_idx_q][31:0] <= acc_wdata;
      end else if (take_acc && acc_write && hit_hi) begin
        mem_q[wr_idx_q][63:32] <= acc_wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // answers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cpu_ack_q   <= 1'b0;
      cpu_rdata_q <= WIN_RESET;
    end else if (ce_in) begin
      cpu_ack_q <= take_cpu;
      if (take_cpu && !cpu_write_in) begin
        cpu_rdata_q <= rd_half;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      dbg_ack_q   <= 1'b0;
      dbg_rdata_q <= WIN_RESET;
    end else if (ce_in) begin
      dbg_ack_q <= take_dbg;
      if (take_dbg && !dbg_write_in) begin
        dbg_rdata_q <= rd_half;
      end
    end
  end

  assign cpu_ack_out             = cpu_ack_q;
  assign cpu_rdata_out           = cpu_rdata_q;
  assign dbg_ack_out             = dbg_ack_q;
  assign dbg_rdata_out           = dbg_rdata_q;
  assign trace_read_pointer_out  = {PTR_HIGH_ZERO, rd_idx_q, PTR_LOW_ZERO};
  assign trace_write_pointer_out = {PTR_HIGH_ZERO, wr_idx_q, PTR_LOW_ZERO};

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  rd_lo_advance_a: assert property (rd_lo |=> rd_idx_q == $past(rd_idx_d))
    else $error("read pointer did not advance after low read");
  rd_wrap_a: assert property (rd_lo && rd_idx_q == IDX_LAST |=> rd_idx_q == PTR_RESET)
    else $error("read pointer did not wrap");
  wr_lo_advance_a: assert property (wr_lo && !trace_valid_in |=> wr_idx_q == $past(wr_idx_d))
    else $error("write pointer did not advance after low write");
  hi_no_move_a: assert property (take_acc && hit_hi |=> $stable(rd_idx_q))
    else $error("high access moved the read pointer");
  lo_read_data_a: assert property (take_cpu && !cpu_write_in && hit_lo
                                   |=> cpu_ack_out && cpu_rdata_out == $past(rd_word[31:0]))
    else $error("low read returned wrong half");
  hi_read_data_a: assert property (take_dbg && !dbg_write_in && hit_hi
                                   |=> dbg_ack_out && dbg_rdata_out == $past(rd_word[63:32]))
    else $error("high read returned wrong half");
  lo_write_store_a: assert property (wr_lo && !trace_valid_in
                                     |=> mem_q[$past(wr_idx_q)][31:0] == $past(acc_wdata))
    else $error("low write not stored");
  trace_store_a: assert property (ce_in && trace_valid_in
                                  |=> mem_q[$past(wr_idx_q)] == $past(trace_word_in))
    else $error("trace word not stored at write pointer");
  ptr_align_a: assert property (trace_read_pointer_out[2:0] == PTR_LOW_ZERO
                                && trace_write_pointer_out[2:0] == PTR_LOW_ZERO)
    else $error("pointer low bits not zero");
  reset_zero_a: assert property ($fell(reset_in) |-> cpu_rdata_out == WIN_RESET
                                 && dbg_rdata_out == WIN_RESET)
    else $error("window data not zero after reset");
  ack_pulse_a: assert property (cpu_ack_out && ce_in |=> !cpu_ack_out)
    else $error("cpu answer longer than one cycle");
  wr_wrap_a: assert property (wr_lo && wr_idx_q == IDX_LAST |=> wr_idx_q == PTR_RESET)
    else $error("write pointer did not wrap");
  hi_keep_wr_a: assert property (take_acc && hit_hi |=> $stable(wr_idx_q))
    else $error("high access moved the write pointer");
  hi_write_store_a: assert property (take_acc && acc_write && hit_hi
                                     |=> mem_q[$past(wr_idx_q)][63:32] == $past(acc_wdata))
    else $error("high write not stored");
  lo_dbg_data_a: assert property (take_dbg && !dbg_write_in && hit_lo
                                  |=> dbg_ack_out && dbg_rdata_out == $past(rd_word[31:0]))
    else $error("debug low read returned wrong half");
  hi_cpu_data_a: assert property (take_cpu && !cpu_write_in && hit_hi
                                  |=> cpu_ack_out && cpu_rdata_out == $past(rd_word[63:32]))
    else $error("cpu high read returned wrong half");
  ce_freeze_a: assert property (!ce_in |=> $stable(rd_idx_q) && $stable(wr_idx_q)
                                && $stable(cpu_ack_out) && $stable(dbg_ack_out))
    else $error("state moved while clock enable low");

  word_pair_c: cover property (take_acc && acc_write && hit_hi ##[1:8] wr_lo);
  rd_wrap_c:   cover property (rd_lo && rd_idx_q == IDX_LAST);
  dbg_read_c:  cover property (take_dbg && !dbg_write_in && hit_lo);
  clash_c:     cover property (cpu_req_in && dbg_req_in && trace_valid_in);
  ce_gap_c:    cover property (!ce_in && (cpu_req_in || dbg_req_in));

endmodule

// [hdl/trace_word_pkg.sv]
// constants for the trace word access port
package trace_word_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int          ADDR_W           = 12;
  localparam logic [11:0] TRACE_WORD_LO_OFF = 12'h0200;
  localparam logic [11:0] TRACE_WORD_HI_OFF = 12'h0208;

  // ---------------------------------------------------------------
  // trace memory geometry
  // ---------------------------------------------------------------
  localparam int          DATA_W     = 32;
  localparam int          WORD_W     = 64;
  localparam int          DEPTH      = 64;
  localparam int          IDX_W      = 6;
  localparam int          BYTE_SHIFT = 3;
  localparam logic [5:0]  IDX_LAST   = 6'h3F;
  localparam logic [5:0]  IDX_ONE    = 6'h01;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [5:0]  PTR_RESET   = 6'h00;
  localparam logic [31:0] WIN_RESET   = 32'h0000_0000;
  localparam logic [63:0] WORD_RESET  = 64'h0000_0000_0000_0000;
  localparam logic [2:0]  PTR_LOW_ZERO = 3'h0;
  localparam logic [22:0] PTR_HIGH_ZERO = 23'h00_0000;

endpackage
